/* rtl/nimh_charge_pkg.sv */
package nimh_charge_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   // timing figures in their own units
   localparam int unsigned CHECK_PERIOD_S   = 31;
   localparam int unsigned HOLDOFF_MIN      = 4;
   localparam int unsigned FLAT_MIN         = 16;
   localparam int unsigned COND_LIMIT_MIN   = 30;
   localparam int unsigned ERROR_BLINK_HZ   = 4;
   localparam int unsigned COND_BLINK_HZ    = 1;
   // tick base: one pulse every 1/8 s
   localparam int unsigned TICK_HZ          = 8;
   localparam longint unsigned TICK_CYCLES  = CLK_HZ / TICK_HZ;
   localparam int unsigned CHECK_TICKS      = CHECK_PERIOD_S * TICK_HZ;
   localparam int unsigned HOLDOFF_TICKS    = HOLDOFF_MIN * 60 * TICK_HZ;
   localparam int unsigned FLAT_TICKS       = FLAT_MIN * 60 * TICK_HZ;
   localparam int unsigned COND_TICKS       = COND_LIMIT_MIN * 60 * TICK_HZ;
   // ticks per half period of each blink
   localparam int unsigned ERROR_HALF_TICKS = TICK_HZ / (2 * ERROR_BLINK_HZ);
   localparam int unsigned COND_HALF_TICKS  = TICK_HZ / (2 * COND_BLINK_HZ);
   // cell check: off-time before sampling, in ticks
   localparam int unsigned SETTLE_TICKS     = 1;
   // duty windows out of a 64-slot frame (25% and 1/64 = 1.56%)
   localparam int unsigned DUTY_SLOTS       = 64;
   localparam int unsigned FINISH_ON_SLOTS  = 16;
   localparam int unsigned HOLD_ON_SLOTS    = 1;
   localparam int unsigned TICKW            = 16;

   typedef enum {
      ST_RESET, ST_AWAIT, ST_COND, ST_BULK, ST_CHECK,
      ST_FINISH, ST_HOLD, ST_ERROR, ST_PAUSE
   } charge_state_t;

   typedef struct packed {
      logic chargedOver;  // cell above charged overvoltage limit
      logic openOver;     // cell above open overvoltage limit
      logic condExit;     // cell above conditioning exit level
      logic thermalStop;  // thermistor past stop level
      logic tempInRange;  // thermistor inside start window
      logic senseLow;     // hysteretic sense comparator: current low
      logic impedanceHigh;// loaded minus open voltage over limit
      logic peakDrop;     // reading more than 2 mV under the peak
      logic newPeak;      // reading above the retained peak
      logic timerFloat;   // timeout resistor pin floating
      logic safetyExpire; // resistor-set charge timer elapsed
      logic underVolt;    // supply lockout active
   } flags_t;
   localparam int unsigned FLAGW = $bits(flags_t);
endpackage : nimh_charge_pkg

/* rtl/flag_sync.sv */
`timescale 1ns/1ns
module flag_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async,
   output      logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] stage1;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               stage1[i] <= 1'b0;
               synced[i] <= 1'b0;
            end else begin
               stage1[i] <= async[i];
               synced[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule : flag_sync

/* rtl/tick_gen.sv */
`timescale 1ns/1ns
module tick_gen #(
   parameter longint unsigned CYCLES = nimh_charge_pkg::TICK_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   output      logic tick
);
   localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] count;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= (count == LAST);
         count <= (count == LAST) ? '0 : count + CW'(1);
      end
   end
endmodule : tick_gen

/* rtl/nimh_charge_state_controller.sv */
`timescale 1ns/1ns
// Contract
// - bulk pauses every 31 s for check
// - status high from bulk through finishing
// - safety timer expiry moves bulk to finishing
// - thermal stop in bulk/finish goes trickle-hold
// - overvoltage by switch level enters error in charging states, except in trickle-hold
// - switch off during each cell check
// - drop 2 mV below peak ends bulk
// - no new peak 16 minutes ends bulk
// - peak and flat ends held off 4 minutes
// - impedance over limit enters error
// - check reading over open limit enters error
// - finishing charges 25% duty, status high
// - finishing restarts timer at half; expiry holds
// - trickle-hold: status low, 1.56% duty
// - trickle-hold left on removal, power, pause
// - conditioning thermal stop or timeout errors
// - error: switch off, status 4 Hz
// - error until removal, then await cell
// - floating timer pin pauses, restart cleared
// - sense comparator drives switch in charging
// - status low without cell, 1 Hz conditioning
// - conditioning exits on level, 30 minute limit
// - await leaves on cell and valid temperature
// - lockout resets state and timers; tick base and duty frame run free
module nimh_charge_state_controller #(
   parameter longint unsigned TICK_CYCLES = nimh_charge_pkg::TICK_CYCLES,
   parameter int unsigned CHECK_TICKS   = nimh_charge_pkg::CHECK_TICKS,
   parameter int unsigned HOLDOFF_TICKS = nimh_charge_pkg::HOLDOFF_TICKS,
   parameter int unsigned FLAT_TICKS    = nimh_charge_pkg::FLAT_TICKS,
   parameter int unsigned COND_TICKS    = nimh_charge_pkg::COND_TICKS
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire nimh_charge_pkg::flags_t flagsAsync,
   output      logic                   chargeSwitchOff,
   output      logic                   statusOut,
   output      logic                   safetyTimerClear,
   output      logic                   safetyTimerHalf,
   output      logic                   checkSample,
   output      logic                   peakClear
);
   localparam int unsigned TW = nimh_charge_pkg::TICKW;

   nimh_charge_pkg::flags_t       flags;
   nimh_charge_pkg::charge_state_t state;
   nimh_charge_pkg::charge_state_t next_state;
   logic          tick;
   logic [TW-1:0] checkCount;
   logic [TW-1:0] holdoffCount;
   logic [TW-1:0] flatCount;
   logic [TW-1:0] condCount;
   logic [TW-1:0] blinkCount;
   logic [5:0]    dutySlot;
   logic          blink;
   logic          settleDone;
   logic          holdoffDone;
   logic          switchOn;
   logic          safetyPrev;
   logic          safetyEdge;

   flag_sync #(.WIDTH(nimh_charge_pkg::FLAGW)) u_sync (
      .clk    (clk),
      .rst    (rst),
      .async  (flagsAsync),
      .synced (flags)
   );

   tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk  (clk),
      .rst  (rst),
      .tick (tick)
   );

   function automatic logic charging(
      input nimh_charge_pkg::charge_state_t s
   );
      charging = (s == nimh_charge_pkg::ST_COND) ||
                 (s == nimh_charge_pkg::ST_BULK) ||
                 (s == nimh_charge_pkg::ST_CHECK) ||
                 (s == nimh_charge_pkg::ST_FINISH) ||
                 (s == nimh_charge_pkg::ST_HOLD);
   endfunction : charging

   function automatic logic inDuty(
      input logic [5:0] slot,
      input int unsigned onSlots
   );
      inDuty = (32'(slot) < onSlots);
   endfunction : inDuty

   // the charge timer is an outside resistor-set oscillator; act on its rising edge
   assign safetyEdge = flags.safetyExpire && !safetyPrev;
   assign holdoffDone = (holdoffCount >= TW'(HOLDOFF_TICKS));
   assign settleDone = (checkCount >= TW'(nimh_charge_pkg::SETTLE_TICKS));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         safetyPrev <= 1'b0;
      end else begin
         safetyPrev <= flags.safetyExpire;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         nimh_charge_pkg::ST_RESET: begin
            next_state = nimh_charge_pkg::ST_AWAIT;
         end
         nimh_charge_pkg::ST_AWAIT: begin
            if (!flags.openOver && flags.tempInRange) begin
               next_state = nimh_charge_pkg::ST_COND;
            end
         end
         nimh_charge_pkg::ST_COND: begin
            if (flags.thermalStop ||
                condCount >= TW'(COND_TICKS)) begin
               next_state = nimh_charge_pkg::ST_ERROR;
            end else if (flags.condExit) begin
               next_state = nimh_charge_pkg::ST_BULK;
            end
         end
         nimh_charge_pkg::ST_BULK: begin
            if (flags.thermalStop) begin
               next_state = nimh_charge_pkg::ST_HOLD;
            end else if (safetyEdge) begin
               next_state = nimh_charge_pkg::ST_FINISH;
            end else if (tick && checkCount >= TW'(CHECK_TICKS - 1)) begin
               next_state = nimh_charge_pkg::ST_CHECK;
            end
         end
         nimh_charge_pkg::ST_CHECK: begin
            // the check is part of bulk: thermal stop and expiry apply too
            if (flags.thermalStop) begin
               next_state = nimh_charge_pkg::ST_HOLD;
            end else if (safetyEdge) begin
               next_state = nimh_charge_pkg::ST_FINISH;
            end else if (tick && settleDone) begin
               if (flags.openOver) begin
                  next_state = nimh_charge_pkg::ST_ERROR;
               end else if (flags.impedanceHigh) begin
                  next_state = nimh_charge_pkg::ST_ERROR;
               end else if (holdoffDone && flags.peakDrop) begin
                  next_state = nimh_charge_pkg::ST_FINISH;
               end else if (holdoffDone && !flags.newPeak &&
                            flatCount >= TW'(FLAT_TICKS)) begin
                  next_state = nimh_charge_pkg::ST_FINISH;
               end else begin
                  next_state = nimh_charge_pkg::ST_BULK;
               end
            end
         end
         nimh_charge_pkg::ST_FINISH: begin
            if (flags.thermalStop || safetyEdge) begin
               next_state = nimh_charge_pkg::ST_HOLD;
            end
         end
         nimh_charge_pkg::ST_HOLD: begin
            if (flags.chargedOver && switchOn) begin
               next_state = nimh_charge_pkg::ST_AWAIT;
            end
         end
         nimh_charge_pkg::ST_ERROR: begin
            if (flags.chargedOver) begin
               next_state = nimh_charge_pkg::ST_AWAIT;
            end
         end
         nimh_charge_pkg::ST_PAUSE: begin
            next_state = nimh_charge_pkg::ST_AWAIT;
         end
         default: begin
            next_state = nimh_charge_pkg::ST_RESET;
         end
      endcase
      // overvoltage by the switch level wins over normal moves in every charging state but hold
      if (state != nimh_charge_pkg::ST_HOLD && charging(state) &&
          ((flags.chargedOver && switchOn) ||
           (flags.openOver && !switchOn))) begin
         next_state = nimh_charge_pkg::ST_ERROR;
      end
      if (flags.timerFloat) begin
         next_state = nimh_charge_pkg::ST_PAUSE;
      end
      if (flags.underVolt) begin
         next_state = nimh_charge_pkg::ST_RESET;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= nimh_charge_pkg::ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // check interval counter, reused as settle count inside the check
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         checkCount <= '0;
      end else if (state != next_state) begin
         checkCount <= '0;
      end else if (tick) begin
         checkCount <= checkCount + TW'(1);
      end
   end

   // hold-off runs from bulk start and saturates; cleared outside bulk
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         holdoffCount <= '0;
      end else if (state != nimh_charge_pkg::ST_BULK &&
                   state != nimh_charge_pkg::ST_CHECK) begin
         holdoffCount <= '0;
      end else if (tick && !holdoffDone) begin
         holdoffCount <= holdoffCount + TW'(1);
      end
   end

   // flat window restarts whenever a check sees a new peak
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flatCount <= '0;
      end else if (state != nimh_charge_pkg::ST_BULK &&
                   state != nimh_charge_pkg::ST_CHECK) begin
         flatCount <= '0;
      end else if (state == nimh_charge_pkg::ST_CHECK && tick &&
                   settleDone && flags.newPeak) begin
         flatCount <= '0;
      end else if (tick && flatCount < TW'(FLAT_TICKS)) begin
         flatCount <= flatCount + TW'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         condCount <= '0;
      end else if (state != nimh_charge_pkg::ST_COND) begin
         condCount <= '0;
      end else if (tick && condCount < TW'(COND_TICKS)) begin
         condCount <= condCount + TW'(1);
      end
   end

   // free duty frame; one slot per tick is too slow, so slots step on clk
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dutySlot <= '0;
      end else begin
         dutySlot <= dutySlot + 6'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blinkCount <= '0;
         blink      <= 1'b0;
      end else if (state != next_state) begin
         blinkCount <= '0;
         blink      <= 1'b0;
      end else if (tick) begin
         if ((state == nimh_charge_pkg::ST_ERROR &&
              blinkCount >= TW'(nimh_charge_pkg::ERROR_HALF_TICKS - 1)) ||
             (state == nimh_charge_pkg::ST_COND &&
              blinkCount >= TW'(nimh_charge_pkg::COND_HALF_TICKS - 1))) begin
            blinkCount <= '0;
            blink      <= !blink;
         end else begin
            blinkCount <= blinkCount + TW'(1);
         end
      end
   end

   // switch on request before the output flop; low-active at the pin
   always_comb begin
      case (state)
         nimh_charge_pkg::ST_BULK: begin
            switchOn = flags.senseLow;
         end
         nimh_charge_pkg::ST_COND,
         nimh_charge_pkg::ST_FINISH: begin
            switchOn = flags.senseLow &&
                       inDuty(dutySlot, nimh_charge_pkg::FINISH_ON_SLOTS);
         end
         nimh_charge_pkg::ST_HOLD: begin
            switchOn = flags.senseLow &&
                       inDuty(dutySlot, nimh_charge_pkg::HOLD_ON_SLOTS);
         end
         default: begin
            switchOn = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chargeSwitchOff <= 1'b1;
         statusOut       <= 1'b0;
      end else begin
         chargeSwitchOff <= !(switchOn && next_state == state);
         case (state)
            nimh_charge_pkg::ST_BULK,
            nimh_charge_pkg::ST_CHECK,
            nimh_charge_pkg::ST_FINISH: begin
               statusOut <= 1'b1;
            end
            nimh_charge_pkg::ST_COND,
            nimh_charge_pkg::ST_ERROR: begin
               statusOut <= blink;
            end
            default: begin
               statusOut <= 1'b0;
            end
         endcase
      end
   end

   // strobes to the outside charge timer and peak store
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         safetyTimerClear <= 1'b1;
         safetyTimerHalf  <= 1'b0;
         checkSample      <= 1'b0;
         peakClear        <= 1'b1;
      end else begin
         safetyTimerClear <= (next_state != state) &&
                             (next_state == nimh_charge_pkg::ST_FINISH ||
                              next_state == nimh_charge_pkg::ST_BULK ||
                              next_state == nimh_charge_pkg::ST_RESET ||
                              next_state == nimh_charge_pkg::ST_PAUSE);
         safetyTimerHalf  <= (next_state == nimh_charge_pkg::ST_FINISH);
         checkSample      <= (state == nimh_charge_pkg::ST_CHECK) &&
                             tick && settleDone;
         peakClear        <= (next_state == nimh_charge_pkg::ST_AWAIT) ||
                             (next_state == nimh_charge_pkg::ST_RESET);
      end
   end
endmodule : nimh_charge_state_controller

/* verification/sense_model.sv */
`timescale 1ns/1ns
module sense_model (
   input  wire logic clk,
   input  wire logic chargeSwitchOff,
   output      logic senseLow
);
   // coil current ramps while the switch is on, decays while off
   int level = 0;
   initial senseLow = 1'h1;
   always @(posedge clk) begin
      if (!chargeSwitchOff && level < 8)
         level <= level + 1;
      else if (chargeSwitchOff && level > 0)
         level <= level - 1;
      // hysteresis band, so the switch does not chatter every cycle
      if (level >= 6)
         senseLow <= 1'h0;
      else if (level <= 2)
         senseLow <= 1'h1;
   end
endmodule : sense_model

/* verification/nimh_charge_asserts.sv */
`timescale 1ns/1ns
module nimh_charge_asserts #(
   parameter longint unsigned TICK_CYCLES = nimh_charge_pkg::TICK_CYCLES,
   parameter int unsigned CHECK_TICKS   = nimh_charge_pkg::CHECK_TICKS,
   parameter int unsigned HOLDOFF_TICKS = nimh_charge_pkg::HOLDOFF_TICKS,
   parameter int unsigned FLAT_TICKS    = nimh_charge_pkg::FLAT_TICKS,
   parameter int unsigned COND_TICKS    = nimh_charge_pkg::COND_TICKS
) (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire nimh_charge_pkg::flags_t flagsAsync,
   input wire logic                    chargeSwitchOff,
   input wire logic                    statusOut,
   input wire logic                    safetyTimerClear,
   input wire logic                    safetyTimerHalf,
   input wire logic                    checkSample,
   input wire logic                    peakClear
);
   localparam longint unsigned MINGAP = CHECK_TICKS * TICK_CYCLES - 1;
   // slack covers tick phase and the settle tick before sampling
   localparam longint unsigned MAXRUN = (CHECK_TICKS + 3) * TICK_CYCLES;
   longint unsigned gap;
   longint unsigned bulkRun;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         gap <= MAXRUN * 4;
      else if (checkSample)
         gap <= 0;
      else if (gap < MAXRUN * 4)
         gap <= gap + 1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         bulkRun <= 0;
      else if (statusOut && !safetyTimerHalf && !checkSample)
         bulkRun <= bulkRun + 1;
      else
         bulkRun <= 0;
   end
   a_reset_outs: assert property (@(posedge clk)
      rst |=> chargeSwitchOff && !statusOut && peakClear && !checkSample)
      else $error("outputs not idle during reset");
   a_sample_off: assert property (@(posedge clk) disable iff (rst)
      checkSample |-> chargeSwitchOff && $past(chargeSwitchOff, 2))
      else $error("switch on at cell check");
   a_sample_pulse: assert property (@(posedge clk) disable iff (rst)
      checkSample |=> !checkSample)
      else $error("check pulse longer than one cycle");
   a_sample_gap: assert property (@(posedge clk) disable iff (rst)
      checkSample |-> gap >= MINGAP)
      else $error("cell checks too close");
   a_bulk_run: assert property (@(posedge clk) disable iff (rst)
      bulkRun <= MAXRUN)
      else $error("bulk ran without a cell check");
   a_finish_high: assert property (@(posedge clk) disable iff (rst)
      safetyTimerHalf |-> statusOut)
      else $error("status low while finishing");
   a_half_clear: assert property (@(posedge clk) disable iff (rst)
      $rose(safetyTimerHalf) |-> safetyTimerClear || $past(safetyTimerClear))
      else $error("finishing timer not cleared");
   a_lockout_off: assert property (@(posedge clk) disable iff (rst)
      flagsAsync.underVolt [*6] |-> chargeSwitchOff && peakClear)
      else $error("lockout did not stop charging");
   a_float_off: assert property (@(posedge clk) disable iff (rst)
      flagsAsync.timerFloat [*6] |-> chargeSwitchOff)
      else $error("switch on while timer pin floats");
   a_idle_off: assert property (@(posedge clk) disable iff (rst)
      peakClear |-> chargeSwitchOff)
      else $error("switch on while awaiting cell");
endmodule : nimh_charge_asserts
bind nimh_charge_state_controller nimh_charge_asserts #(
   .TICK_CYCLES(TICK_CYCLES), .CHECK_TICKS(CHECK_TICKS),
   .HOLDOFF_TICKS(HOLDOFF_TICKS), .FLAT_TICKS(FLAT_TICKS),
   .COND_TICKS(COND_TICKS)
) u_chk (
   .clk(clk), .rst(rst), .flagsAsync(flagsAsync),
   .chargeSwitchOff(chargeSwitchOff), .statusOut(statusOut),
   .safetyTimerClear(safetyTimerClear), .safetyTimerHalf(safetyTimerHalf),
   .checkSample(checkSample), .peakClear(peakClear)
);

/* verification/tb.sv */
`timescale 1ns/1ns
module tb;
   logic                    clk = 1'h0;
   logic                    rst = 1'h1;
   nimh_charge_pkg::flags_t flags = '0;
   nimh_charge_pkg::flags_t flagsIn;
   logic                    senseLow;
   logic                    chargeSwitchOff;
   logic                    statusOut;
   logic                    safetyTimerClear;
   logic                    safetyTimerHalf;
   logic                    checkSample;
   logic                    peakClear;
   int                      bad_count = 0;
   int                      n_checks = 0;
   always #2 clk = ~clk;
   always_comb begin
      flagsIn = flags;
      flagsIn.senseLow = senseLow;
   end
   // 4 cycles a tick: check every 32, holdoff 64, flat 128, cond 256
   nimh_charge_state_controller #(.TICK_CYCLES(4), .CHECK_TICKS(8),
      .HOLDOFF_TICKS(16), .FLAT_TICKS(32), .COND_TICKS(64)) u_dut (
      .clk(clk), .rst(rst), .flagsAsync(flagsIn),
      .chargeSwitchOff(chargeSwitchOff), .statusOut(statusOut),
      .safetyTimerClear(safetyTimerClear), .safetyTimerHalf(safetyTimerHalf),
      .checkSample(checkSample), .peakClear(peakClear));
   sense_model u_sense (.clk(clk), .chargeSwitchOff(chargeSwitchOff),
      .senseLow(senseLow));
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic chk(input string what, input int lo, input int hi,
                      input logic [8:0] got);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'h1) begin
         $display("unexpected %s expected %0d..%0d seen %0d",
                  what, lo, hi, got);
         bad_count++;
      end
   endtask : chk
   function automatic logic obs(input int sel);
      case (sel)
         0: return chargeSwitchOff;
         1: return statusOut;
         2: return safetyTimerHalf;
         3: return checkSample;
         4: return peakClear;
         default: return safetyTimerClear;
      endcase
   endfunction : obs
   task automatic waitFor(input int sel, input logic val, input int lim,
                          input string what);
      int i;
      i = 0;
      while (obs(sel) !== val && i < lim) begin
         @(negedge clk);
         i++;
      end
      chk(what, val, val, obs(sel));
      if (obs(sel) !== val)
         test_done();
   endtask : waitFor
   task automatic count(input int sel, input logic val, input int n,
                        output int c);
      c = 0;
      repeat (n) begin
         @(negedge clk);
         if (obs(sel) === val)
            c++;
      end
   endtask : count
   // length of one full high phase of the status output
   task automatic highRun(output int n);
      waitFor(1, 1'h0, 60, "status low");
      waitFor(1, 1'h1, 60, "status high");
      n = 0;
      while (statusOut === 1'h1 && n < 60) begin
         @(negedge clk);
         n++;
      end
   endtask : highRun
   task automatic restart;
      rst = 1'h1;
      flags = '0;
      repeat (3) @(negedge clk);
      rst = 1'h0;
   endtask : restart
   task automatic toBulk;
      restart();
      flags.tempInRange = 1'h1;
      flags.condExit = 1'h1;
      repeat (10) @(negedge clk);
      chk("bulk status", 1, 1, statusOut);
   endtask : toBulk
   task automatic t_await;
      int n;
      restart();
      count(1, 1'h1, 30, n);
      chk("status without cell", 0, 0, n);
      flags.tempInRange = 1'h1;
      highRun(n);
      highRun(n);
      chk("cond blink half", 16, 16, n);
      flags.thermalStop = 1'h1;
      repeat (8) @(negedge clk);
      highRun(n);
      chk("cond thermal blink", 4, 4, n);
      flags.thermalStop = 1'h0;
      flags.chargedOver = 1'h1;
      flags.openOver = 1'h1;
      waitFor(4, 1'h1, 12, "removal to await");
      flags.chargedOver = 1'h0;
      flags.openOver = 1'h0;
      repeat (276) @(negedge clk);
      highRun(n);
      chk("cond timeout blink", 4, 4, n);
      $display("t_await done");
   endtask : t_await
   task automatic t_bulk;
      int n;
      toBulk();
      flags.peakDrop = 1'h1;
      count(0, 1'h0, 16, n);
      chk("bulk switching", 1, 15, n);
      waitFor(3, 1'h1, 60, "first check");
      repeat (2) @(negedge clk);
      chk("holdoff keeps bulk", 0, 0, safetyTimerHalf);
      waitFor(2, 1'h1, 100, "peak drop finish");
      count(0, 1'h0, 128, n);
      chk("finish duty", 1, 36, n);
      flags.thermalStop = 1'h1;
      waitFor(1, 1'h0, 10, "thermal to hold");
      count(0, 1'h0, 128, n);
      chk("hold duty", 1, 4, n);
      flags.openOver = 1'h1;
      flags.impedanceHigh = 1'h1;
      count(1, 1'h1, 40, n);
      chk("hold persists", 0, 0, n);
      $display("t_bulk done");
   endtask : t_bulk
   task automatic t_flat;
      toBulk();
      repeat (100) @(negedge clk);
      chk("flat too early", 0, 0, safetyTimerHalf);
      waitFor(2, 1'h1, 200, "flat finish");
      flags.safetyExpire = 1'h1;
      waitFor(1, 1'h0, 12, "finish expiry");
      $display("t_flat done");
   endtask : t_flat
   task automatic t_fault;
      int n;
      toBulk();
      flags.safetyExpire = 1'h1;
      waitFor(5, 1'h1, 10, "expiry timer clear");
      waitFor(2, 1'h1, 10, "expiry finish");
      repeat (20) @(negedge clk);
      chk("level expiry ignored", 1, 1, safetyTimerHalf);
      flags.openOver = 1'h1;
      highRun(n);
      chk("overvoltage blink", 4, 4, n);
      count(0, 1'h0, 32, n);
      chk("error switch on", 0, 0, n);
      toBulk();
      flags.impedanceHigh = 1'h1;
      highRun(n);
      chk("impedance blink", 4, 4, n);
      $display("t_fault done");
   endtask : t_fault
   task automatic t_float;
      int n;
      toBulk();
      flags.timerFloat = 1'h1;
      repeat (6) @(negedge clk);
      count(0, 1'h0, 20, n);
      chk("float switch on", 0, 0, n);
      flags.timerFloat = 1'h0;
      waitFor(4, 1'h1, 12, "float restart");
      repeat (12) @(negedge clk);
      flags.underVolt = 1'h1;
      repeat (6) @(negedge clk);
      count(0, 1'h0, 20, n);
      chk("lockout switch on", 0, 0, n);
      chk("lockout status", 0, 0, statusOut);
      $display("t_float done");
   endtask : t_float
   initial begin
      t_await();
      t_bulk();
      t_flat();
      t_fault();
      t_float();
      test_done();
   end
endmodule : tb
